// >>> dac_ctrl.sv
`timescale 1ns/1ps
module dac_ctrl
  import dac_ctrl_pkg::*;
#(
  // arbitrary identification value
  parameter logic [7:0] ID_VALUE = 8'h5a
)(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire host_req_t host_req_i,
  output logic [9:0] host_data_o,
  output logic host_data_oe_n_o,
  input wire logic palette_sel_in_hi_i,
  input wire logic palette_sel_in_lo_i,
  input wire pixel_t pix_i,
  input wire logic blank_n_i,
  input wire logic vsync_i,
  output pixel_t dac_o,
  output logic dac_enable_o,
  output logic [1:0] overlay_sel_o,
  output logic bypass_active_o,
  output logic blank_n_o,
  output logic prog_clock_out_o,
  output logic load_clock_out_o,
  output logic cal_start_o,
  output logic seq_restart_o,
  output logic [1:0] pixel_phase_o,
  output logic normal_mode_o,
  output logic [1:0] bypass_colour_o,
  output logic [3:0] colour_mode_o,
  output logic sync_on_green_o,
  output logic pedestal_o
);

  mode_reg_t mode_q, mode_d;
  cmd1_t cmd1_q, cmd1_d;
  cmd2_t cmd2_q, cmd2_d;
  cmd3_t cmd3_q, cmd3_d;
  logic [7:0] mask_q, mask_d;
  logic [10:0] ptr_q, ptr_d;
  logic hi_next_q, hi_next_d;
  logic last_rd_q, last_rd_d;
  logic [1:0] rgb_q, rgb_d;
  logic half_q, half_d;
  logic [9:0] rdata_q, rdata_d;
  logic oe_n_q, oe_n_d;
  logic cal_q, cal_d;
  logic restart_q, restart_d;
  // resets low like the idle pin, so no false edge after reset
  logic vsync_q;
  seq_state_t seq_q, seq_d;

  logic [7:0] wbyte;
  logic hi_sel;
  logic in_auto;
  logic byte_done;
  mode_reg_t mode_w;

  // unmapped offsets read back as zero
  function automatic logic [7:0] ctrl_read(
    input logic [10:0] a,
    input logic [7:0] m,
    input logic [7:0] c1,
    input logic [7:0] c2,
    input logic [7:0] c3
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_ID: v = ID_VALUE;
      OFS_MASK: v = m;
      OFS_CMD1: v = c1;
      OFS_CMD2: v = c2;
      OFS_CMD3: v = c3;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    wbyte = host_req_i.data[7:0];
    mode_w = mode_reg_t'(wbyte);
    mode_d = mode_q;
    cmd1_d = cmd1_q;
    cmd2_d = cmd2_q;
    cmd3_d = cmd3_q;
    mask_d = mask_q;
    ptr_d = ptr_q;
    hi_next_d = hi_next_q;
    last_rd_d = last_rd_q;
    rgb_d = rgb_q;
    half_d = half_q;
    rdata_d = 10'h000;
    oe_n_d = 1'b1;
    cal_d = 1'b0;
    restart_d = 1'b0;
    seq_d = seq_q;
    hi_sel = 1'b0;
    byte_done = 1'b0;

    // cursor registers and cursor image walk forward on each control access
    in_auto = (ptr_q >= CUR_FIRST && ptr_q <= CUR_LAST) ||
      ptr_q >= IMG_FIRST;
    // recalibrate on vsync only while the manual bit rests at zero
    if (vsync_i && !vsync_q && cmd1_q.auto_recal_bit &&
        !mode_q.load_calibrate_bit)
    begin
      cal_d = 1'b1;
    end

    // every field of an access is taken on its strobe edge only
    if (host_req_i.acc)
    begin
      last_rd_d = host_req_i.rd;
      hi_next_d = 1'b0;
      oe_n_d = !host_req_i.rd;
      unique case (host_req_i.sel)
        SEL_ADDR:
        begin
          // a changed access type or another register restarts at low
          hi_sel = hi_next_q && last_rd_q == host_req_i.rd &&
            cmd1_q.ptr_upper_enable;
          hi_next_d = !hi_sel;
          if (host_req_i.rd)
          begin
            rdata_d = hi_sel ? {7'h00, ptr_q[10:8]} : {2'h0, ptr_q[7:0]};
          end
          else
          begin
            // a pointer write restarts the colour walk
            rgb_d = 2'h0;
            half_d = 1'b0;
            if (hi_sel)
            begin
              ptr_d = {wbyte[2:0], ptr_q[7:0]};
            end
            else
            begin
              ptr_d = {ptr_q[10:8], wbyte};
            end
          end
        end
        SEL_MODE:
        begin
          if (host_req_i.rd)
          begin
            rdata_d = {2'h0, mode_q};
          end
          else
          begin
            mode_d = mode_w;
            if (mode_w.load_calibrate_bit && !mode_q.load_calibrate_bit)
            begin
              cal_d = 1'b1;
            end
            // restart bit walk over successive mode writes
            unique case (seq_q)
              SEQ_IDLE: seq_d = mode_w.seq_restart_bit ? SEQ_ONE : SEQ_IDLE;
              SEQ_ONE: seq_d = mode_w.seq_restart_bit ? SEQ_ONE : SEQ_ZERO;
              SEQ_ZERO:
              begin
                seq_d = SEQ_IDLE;
                restart_d = mode_w.seq_restart_bit;
              end
              default: seq_d = SEQ_IDLE;
            endcase
          end
        end
        SEL_CTRL:
        begin
          if (host_req_i.rd)
          begin
            // top bits stay zero for every control register
            rdata_d = {2'h0, ctrl_read(ptr_q, mask_q, cmd1_q, cmd2_q,
              cmd3_q)};
          end
          else
          begin
            unique case (ptr_q)
              OFS_MASK: mask_d = wbyte;
              OFS_CMD1: cmd1_d = cmd1_t'(wbyte);
              OFS_CMD2: cmd2_d = cmd2_t'(wbyte);
              OFS_CMD3: cmd3_d = cmd3_t'(wbyte);
              default: ;
            endcase
          end
          if (in_auto)
          begin
            ptr_d = ptr_q + 11'h001;
          end
        end
        SEL_PAL:
        begin
          // colour storage sits elsewhere; only the sequencing lives here
          byte_done = mode_q.host_width_bit || half_q;
          half_d = mode_q.host_width_bit ? 1'b0 : !half_q;
          if (byte_done)
          begin
            rgb_d = rgb_q + 2'h1;
            if (rgb_q == 2'h2)
            begin
              rgb_d = 2'h0;
              if (ptr_q >= OVL_FIRST && ptr_q <= OVL_LAST)
              begin
                ptr_d = ptr_q + 11'h001;
              end
            end
          end
        end
        default: ;
      endcase
      // byte-wide host: upper lanes never carry stale bits
      if (!mode_q.host_width_bit)
      begin
        rdata_d[9:8] = 2'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= mode_reg_t'(MODE_RST);
      cmd1_q <= cmd1_t'(CMD1_RST);
      cmd2_q <= cmd2_t'(CMD2_RST);
      cmd3_q <= cmd3_t'(CMD3_RST);
      mask_q <= MASK_RST;
      ptr_q <= PTR_RST;
      hi_next_q <= 1'b0;
      last_rd_q <= 1'b0;
      rgb_q <= 2'h0;
      half_q <= 1'b0;
      rdata_q <= 10'h000;
      oe_n_q <= 1'b1;
      cal_q <= 1'b0;
      restart_q <= 1'b0;
      vsync_q <= 1'b0;
      seq_q <= SEQ_IDLE;
    end
    else
    begin
      mode_q <= mode_d;
      cmd1_q <= cmd1_d;
      cmd2_q <= cmd2_d;
      cmd3_q <= cmd3_d;
      mask_q <= mask_d;
      ptr_q <= ptr_d;
      hi_next_q <= hi_next_d;
      last_rd_q <= last_rd_d;
      rgb_q <= rgb_d;
      half_q <= half_d;
      rdata_q <= rdata_d;
      oe_n_q <= oe_n_d;
      cal_q <= cal_d;
      restart_q <= restart_d;
      vsync_q <= vsync_i;
      seq_q <= seq_d;
    end
  end

  // pixel path
  pixel_t dac_q, dac_d;
  logic en_q, en_d;
  logic [1:0] ovl_q, ovl_d;
  logic byp_q, byp_d;
  logic [6:0] blank_pipe_q, blank_pipe_d;
  logic blank_q, blank_d;
  logic [1:0] phase_q, phase_d;
  logic [4:0] div_q, div_d;
  logic prg_q, prg_d;
  logic load_q, load_d;
  logic norm_q, norm_d;
  logic [1:0] ps;
  logic [7:0] blank_taps;

  function automatic logic [9:0] shape_px(
    input logic [9:0] v,
    input logic [7:0] m,
    input logic res
  );
    logic [9:0] x;
    x = {v[9:8], v[7:0] & m};
    return res ? x : {x[9:2], 2'h0};
  endfunction

  always_comb
  begin
    ps = {palette_sel_in_hi_i, palette_sel_in_lo_i};
    en_d = 1'b1;
    ovl_d = 2'h0;
    byp_d = 1'b0;
    unique case (cmd1_q.select_function_field)
      FN_PALSEL: en_d = ps == mode_q.select_match_field;
      FN_BYPASS: byp_d = palette_sel_in_hi_i;
      FN_OVERLAY: ovl_d = ps;
      FN_IGNORE: en_d = 1'b1;
    endcase

    // mask first, then resolution, so both cut the same code
    dac_d.r = shape_px(pix_i.r, mask_q, mode_q.dac_resolution_bit);
    dac_d.g = shape_px(pix_i.g, mask_q, mode_q.dac_resolution_bit);
    dac_d.b = shape_px(pix_i.b, mask_q, mode_q.dac_resolution_bit);
    if (!en_d)
    begin
      dac_d = '0;
    end

    // pipe is as deep as the widest delay code needs
    blank_pipe_d = {blank_pipe_q[5:0], blank_n_i};
    blank_taps = {blank_pipe_q, blank_n_i};
    blank_d = blank_taps[cmd3_q.blank_delay_field];

    // restart pulse wins over the free count
    phase_d = restart_q ? 2'h0 : phase_q + 2'h1;
    // one free counter feeds both dividers, so their edges align
    div_d = div_q + 5'h01;
    prg_d = div_q[PRG_TAP[cmd3_q.prog_clk_div_field]];
    load_d = div_q[LOAD_TAP[cmd3_q.mux_mode_field]];

    norm_d = mode_q.op_mode_field == 2'h0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dac_q <= '0;
      en_q <= 1'b0;
      ovl_q <= 2'h0;
      byp_q <= 1'b0;
      blank_pipe_q <= 7'h00;
      blank_q <= 1'b0;
      phase_q <= 2'h0;
      div_q <= 5'h00;
      prg_q <= 1'b0;
      load_q <= 1'b0;
      norm_q <= 1'b0;
    end
    else
    begin
      dac_q <= dac_d;
      en_q <= en_d;
      ovl_q <= ovl_d;
      byp_q <= byp_d;
      blank_pipe_q <= blank_pipe_d;
      blank_q <= blank_d;
      phase_q <= phase_d;
      div_q <= div_d;
      prg_q <= prg_d;
      load_q <= load_d;
      norm_q <= norm_d;
    end
  end

  // register fields go out straight from their flip-flops
  assign host_data_o = rdata_q;
  assign host_data_oe_n_o = oe_n_q;
  assign dac_o = dac_q;
  assign dac_enable_o = en_q;
  assign overlay_sel_o = ovl_q;
  assign bypass_active_o = byp_q;
  assign blank_n_o = blank_q;
  assign prog_clock_out_o = prg_q;
  assign load_clock_out_o = load_q;
  assign cal_start_o = cal_q;
  assign seq_restart_o = restart_q;
  assign pixel_phase_o = phase_q;
  assign normal_mode_o = norm_q;
  assign bypass_colour_o = cmd1_q.bypass_colour_field;
  assign colour_mode_o = cmd2_q.colour_mode_field;
  assign sync_on_green_o = cmd2_q.sync_on_green_bit;
  assign pedestal_o = cmd2_q.pedestal_bit;

endmodule

// >>> dac_ctrl_assertions.sv
`timescale 1ns/1ps
module dac_ctrl_assertions
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire host_req_t host_req_i,
  input wire logic [9:0] host_data_o,
  input wire logic host_data_oe_n_o,
  input wire logic palette_sel_in_hi_i,
  input wire logic palette_sel_in_lo_i,
  input wire pixel_t pix_i,
  input wire pixel_t dac_o,
  input wire logic dac_enable_o,
  input wire logic [1:0] overlay_sel_o,
  input wire logic bypass_active_o,
  input wire logic cal_start_o,
  input wire logic seq_restart_o,
  input wire logic [1:0] pixel_phase_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  read_answer_a:
    assert property (host_req_i.acc && host_req_i.rd |=> !host_data_oe_n_o)
    else $error("read got no answer");
  oe_idle_a:
    assert property (!(host_req_i.acc && host_req_i.rd) |=> host_data_oe_n_o)
    else $error("read data driven unasked");
  top_zero_a:
    assert property (host_data_o[9:8] == 2'h0)
    else $error("reserved read bits not zero");
  restart_zero_a:
    assert property (seq_restart_o |=> pixel_phase_o == 2'h0)
    else $error("phase not restarted");
  cal_pulse_a:
    assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration pulse too long");
  overlay_follow_a:
    assert property (overlay_sel_o != 2'h0 |-> overlay_sel_o ==
      {$past(palette_sel_in_hi_i), $past(palette_sel_in_lo_i)})
    else $error("overlay select wrong");
  bypass_follow_a:
    assert property (bypass_active_o |->
      $past(palette_sel_in_hi_i) && overlay_sel_o == 2'h0)
    else $error("bypass without select");
  high_pass_a:
    assert property (dac_enable_o |-> dac_o.g[9:8] == $past(pix_i.g[9:8]))
    else $error("upper pixel bits altered");
  restart_c: cover property (seq_restart_o);
  cal_c: cover property (cal_start_o);
  overlay_c: cover property (overlay_sel_o == 2'h3);
endmodule
bind dac_ctrl dac_ctrl_assertions i_dac_ctrl_assertions (.*);

// >>> dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  localparam logic [1:0] SEL_ADDR = 2'h0;
  localparam logic [1:0] SEL_PAL = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;

  localparam logic [10:0] OFS_ID = 11'h003;
  localparam logic [10:0] OFS_MASK = 11'h004;
  localparam logic [10:0] OFS_CMD1 = 11'h005;
  localparam logic [10:0] OFS_CMD2 = 11'h006;
  localparam logic [10:0] OFS_CMD3 = 11'h007;
  localparam logic [10:0] CUR_FIRST = 11'h200;
  localparam logic [10:0] CUR_LAST = 11'h204;
  localparam logic [10:0] IMG_FIRST = 11'h400;
  localparam logic [10:0] OVL_FIRST = 11'h303;
  localparam logic [10:0] OVL_LAST = 11'h304;

  localparam logic [7:0] MODE_RST = 8'hff;
  localparam logic [7:0] CMD1_RST = 8'h00;
  localparam logic [7:0] CMD2_RST = 8'hff;
  localparam logic [7:0] CMD3_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [10:0] PTR_RST = 11'h000;

  localparam logic [1:0] FN_PALSEL = 2'h0;
  localparam logic [1:0] FN_BYPASS = 2'h1;
  localparam logic [1:0] FN_OVERLAY = 2'h2;
  localparam logic [1:0] FN_IGNORE = 2'h3;

  // divider tap per field code: clock = pixel / 2^(tap+1)
  localparam logic [2:0] PRG_TAP [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [2:0] LOAD_TAP [4] = '{3'h0, 3'h2, 3'h0, 3'h1};

  typedef struct packed {
    logic [1:0] select_match_field;
    logic load_calibrate_bit;
    logic [1:0] op_mode_field;
    logic host_width_bit;
    logic dac_resolution_bit;
    logic seq_restart_bit;
  } mode_reg_t;

  typedef struct packed {
    logic [1:0] bypass_colour_field;
    logic [1:0] select_function_field;
    logic ptr_upper_enable;
    logic spare2;
    logic spare1;
    logic auto_recal_bit;
  } cmd1_t;

  typedef struct packed {
    logic [3:0] colour_mode_field;
    logic pedestal_bit;
    logic sync_on_green_bit;
    logic [1:0] spare;
  } cmd2_t;

  typedef struct packed {
    logic [1:0] mux_mode_field;
    logic spare5;
    logic [2:0] blank_delay_field;
    logic [1:0] prog_clk_div_field;
  } cmd3_t;

  typedef struct packed {
    logic acc;
    logic rd;
    logic [1:0] sel;
    logic [9:0] data;
  } host_req_t;

  typedef struct packed {
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } pixel_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_ONE = 3'b010,
    SEQ_ZERO = 3'b100
  } seq_state_t;

endpackage

// >>> dac_host_model.sv
`timescale 1ns/1ps
module dac_host_model
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [9:0] host_data_o,
  input wire logic host_data_oe_n_o,
  output host_req_t host_req_o
);
  logic [9:0] rdata;
  initial host_req_o = '0;
  // released bus shows the inverse so stale values never look valid
  task automatic acc(input logic rd, input logic [1:0] sel,
    input logic [9:0] d);
    @(negedge ref_clk_i);
    host_req_o = '{1'b1, rd, sel, d};
    @(negedge ref_clk_i);
    // read answer stands only in the cycle right after the strobe edge
    if (rd)
    begin
      rdata = host_data_oe_n_o ? ~host_data_o : host_data_o;
    end
    host_req_o = '{1'b0, ~rd, ~sel, ~d};
  endtask
  task automatic creg(input logic rd, input logic [7:0] a,
    input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h05)
      v[2] = 1'b0;
    if (a == 8'h06)
      v[1:0] = 2'h0;
    if (a == 8'h07)
      v[5] = 1'b0;
    acc(1'b0, SEL_ADDR, {2'h0, a});
    acc(rd, SEL_CTRL, {2'h0, v});
  endtask
  task automatic restart(input logic [7:0] m);
    acc(1'b0, SEL_MODE, {2'h0, m | 8'h01});
    acc(1'b0, SEL_MODE, {2'h0, m & 8'hfe});
    acc(1'b0, SEL_MODE, {2'h0, m | 8'h01});
  endtask
  task automatic calibrate(input logic [7:0] m);
    acc(1'b0, SEL_MODE, {2'h0, m & 8'hdf});
    acc(1'b0, SEL_MODE, {2'h0, m | 8'h20});
    acc(1'b0, SEL_MODE, {2'h0, m & 8'hdf});
  endtask
endmodule

// >>> test_video_dac_mode_control_regs.sv
`timescale 1ns/1ps
module test_video_dac_mode_control_regs;
  import dac_ctrl_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ps_hi = 1'b0;
  logic ps_lo = 1'b0;
  logic blank_n = 1'b1;
  logic vsync = 1'b0;
  pixel_t pix = '0;
  pixel_t dac;
  host_req_t req;
  logic [9:0] rdat;
  logic oe_n, dac_en, byp, blank_o, prg, ld, cal, rsp, nrm, sog, ped;
  logic prg_l, ld_l, rsp_l;
  logic [1:0] ovl, ph, ph_after, bcol;
  logic [3:0] cmode;
  int bad_count = 0;
  int n_compared = 0;
  int cal_n, rsp_n, prg_n, ld_n;
  dac_host_model i_dac_host_model (.ref_clk_i(ref_clk_i),
    .host_data_o(rdat), .host_data_oe_n_o(oe_n), .host_req_o(req));
  dac_ctrl #(.ID_VALUE(ID_CODE)) i_dac_ctrl (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .host_req_i(req), .host_data_o(rdat),
    .host_data_oe_n_o(oe_n), .palette_sel_in_hi_i(ps_hi),
    .palette_sel_in_lo_i(ps_lo), .pix_i(pix), .blank_n_i(blank_n),
    .vsync_i(vsync), .dac_o(dac), .dac_enable_o(dac_en),
    .overlay_sel_o(ovl), .bypass_active_o(byp), .blank_n_o(blank_o),
    .prog_clock_out_o(prg), .load_clock_out_o(ld), .cal_start_o(cal),
    .seq_restart_o(rsp), .pixel_phase_o(ph), .normal_mode_o(nrm),
    .bypass_colour_o(bcol), .colour_mode_o(cmode),
    .sync_on_green_o(sog), .pedestal_o(ped));
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    prg_l <= prg;
    ld_l <= ld;
    rsp_l <= rsp;
    if (rsp_l)
      ph_after <= ph;
    cal_n <= cal_n + int'(cal);
    rsp_n <= rsp_n + int'(rsp);
    prg_n <= prg_n + int'(prg && !prg_l);
    ld_n <= ld_n + int'(ld && !ld_l);
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [9:0] d);
    i_dac_host_model.acc(1'b0, s, d);
  endtask
  task automatic rchk(input logic [1:0] s, input logic [9:0] e);
    i_dac_host_model.acc(1'b1, s, 10'h000);
    chk(i_dac_host_model.rdata, e);
  endtask
  task automatic cw(input logic [7:0] a, input logic [7:0] d);
    i_dac_host_model.creg(1'b0, a, d);
  endtask
  task automatic cchk(input logic [7:0] a, input logic [9:0] e);
    i_dac_host_model.creg(1'b1, a, 8'h00);
    chk(i_dac_host_model.rdata, e);
  endtask
  task automatic t_reset;
    chk({6'h0, cmode}, 10'h00f);
    chk({5'h00, sog, ped, bcol, nrm}, 10'h018);
    rchk(SEL_MODE, 10'h0ff);
    cchk(8'h05, 10'h000);
    cchk(8'h06, 10'h0ff);
    cchk(8'h07, 10'h0ff);
    cchk(8'h04, 10'h0ff);
  endtask
  task automatic t_regs;
    wr(SEL_MODE, 10'h385);
    rchk(SEL_MODE, 10'h085);
    chk({9'h0, nrm}, 10'h001);
    cw(8'h06, 8'h97);
    cchk(8'h06, 10'h094);
    chk({6'h0, cmode}, 10'h009);
    chk({8'h0, sog, ped}, 10'h002);
    cw(8'h05, 8'h84);
    cchk(8'h05, 10'h080);
    chk({8'h0, bcol}, 10'h002);
    cw(8'h03, 8'h00);
    cchk(8'h03, {2'h0, ID_CODE});
    cw(8'h10, 8'h55);
    cchk(8'h10, 10'h000);
  endtask
  // counters run free; each check takes a baseline first
  task automatic t_seq;
    int r0;
    int c0;
    r0 = rsp_n;
    i_dac_host_model.restart(8'h84);
    tick(3);
    chk(10'(rsp_n - r0), 10'h001);
    chk({8'h0, ph_after}, 10'h000);
    c0 = cal_n;
    i_dac_host_model.calibrate(8'h85);
    tick(2);
    chk(10'(cal_n - c0), 10'h001);
    cw(8'h05, 8'h01);
    vsync = 1'b1;
    tick(3);
    vsync = 1'b0;
    tick(3);
    chk(10'(cal_n - c0), 10'h002);
    wr(SEL_MODE, 10'h0a5);
    vsync = 1'b1;
    tick(3);
    vsync = 1'b0;
    tick(3);
    chk(10'(cal_n - c0), 10'h003);
    wr(SEL_MODE, 10'h085);
    cw(8'h05, 8'h00);
  endtask
  task automatic t_pixel;
    cw(8'h04, 8'h0f);
    pix = '{10'h3ff, 10'h3ff, 10'h3ff};
    ps_hi = 1'b1;
    tick(2);
    chk(dac.r, 10'h30c);
    chk({9'h0, dac_en}, 10'h001);
    ps_lo = 1'b1;
    tick(2);
    chk({9'h0, dac_en}, 10'h000);
    cw(8'h05, 8'h30);
    tick(2);
    chk({9'h0, dac_en}, 10'h001);
    cw(8'h05, 8'h20);
    tick(2);
    chk({8'h0, ovl}, 10'h003);
    cw(8'h05, 8'h10);
    tick(2);
    chk({9'h0, byp}, 10'h001);
    ps_hi = 1'b0;
    tick(2);
    chk({9'h0, byp}, 10'h000);
    cw(8'h05, 8'h30);
    wr(SEL_MODE, 10'h087);
    tick(2);
    chk(dac.b, 10'h30f);
    cw(8'h04, 8'hff);
  endtask
  task automatic t_ptr;
    cw(8'h05, 8'h08);
    wr(SEL_ADDR, 10'h000);
    wr(SEL_ADDR, 10'h002);
    repeat (5) wr(SEL_CTRL, 10'h000);
    rchk(SEL_ADDR, 10'h005);
    rchk(SEL_ADDR, 10'h002);
    wr(SEL_ADDR, 10'h0ff);
    wr(SEL_ADDR, 10'h007);
    wr(SEL_CTRL, 10'h000);
    rchk(SEL_ADDR, 10'h000);
    rchk(SEL_ADDR, 10'h000);
    wr(SEL_ADDR, 10'h003);
    wr(SEL_ADDR, 10'h003);
    repeat (3) wr(SEL_PAL, 10'h000);
    rchk(SEL_ADDR, 10'h004);
    // byte-wide host: six bytes make one colour entry
    wr(SEL_MODE, 10'h083);
    repeat (3) wr(SEL_PAL, 10'h000);
    rchk(SEL_ADDR, 10'h004);
    repeat (3) wr(SEL_PAL, 10'h000);
    rchk(SEL_ADDR, 10'h005);
    wr(SEL_MODE, 10'h087);
    wr(SEL_ADDR, 10'h005);
    wr(SEL_ADDR, 10'h000);
    wr(SEL_CTRL, 10'h000);
  endtask
  task automatic t_clk;
    int k;
    int p0;
    int l0;
    for (int i = 0; i < 2; i++)
    begin
      cw(8'h07, {i[1:0], 1'b1, 3'(2 * i), i[1:0]});
      cchk(8'h07, {2'h0, i[1:0], 1'b0, 3'(2 * i), i[1:0]});
      tick(40);
      p0 = prg_n;
      l0 = ld_n;
      tick(32);
      chk(10'(prg_n - p0), 10'(32 >> (PRG_TAP[i] + 1)));
      chk(10'(ld_n - l0), 10'(32 >> (LOAD_TAP[i] + 1)));
      blank_n = 1'b0;
      tick(1);
      blank_n = 1'b1;
      k = 1;
      while (blank_o !== 1'b0 && k < 20)
      begin
        tick(1);
        k++;
      end
      chk(10'(k), 10'(2 * i + 1));
      tick(12);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole sequence needs about 400 cycles; limit is some fifty times that
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    tick(2);
    rst_n_i = 1'b1;
    t_reset;
    t_regs;
    t_seq;
    t_pixel;
    t_ptr;
    t_clk;
    tally_and_finish;
  end
endmodule
